// file: shared/drcto_consts.vh
`ifndef DRCTO_CONSTS_VH
`define DRCTO_CONSTS_VH

// ==========================================================
// register offsets
`define DRCTO_ADDR_CTRL 7'h44
`define DRCTO_ADDR_HOLD 7'h45
`define DRCTO_ADDR_RATE 7'h46

// ==========================================================
// reset values
`define DRCTO_RST_CTRL 8'h0f
`define DRCTO_RST_HOLD 4'h7
`define DRCTO_RST_ATTACK 4'h0
`define DRCTO_RST_DECAY 4'h0
`define DRCTO_RST_THR 3'h3
`define DRCTO_RST_HYS 2'h3

// ==========================================================
// field positions
`define DRCTO_CTRL_EN_BIT 6
`define DRCTO_CTRL_THR_HI 4
`define DRCTO_CTRL_THR_LO 2
`define DRCTO_CTRL_HYS_HI 1
`define DRCTO_CTRL_HYS_LO 0
`define DRCTO_HOLD_HI 6
`define DRCTO_HOLD_LO 3
`define DRCTO_ATTACK_HI 7
`define DRCTO_ATTACK_LO 4
`define DRCTO_DECAY_HI 3
`define DRCTO_DECAY_LO 0

// ==========================================================
// hold lengths in word clocks, rate steps (lsb = 2^-21 dB)
`define DRCTO_HOLD_BASE 18'h00020
`define DRCTO_HOLD_C13 18'h18000
`define DRCTO_HOLD_C14 18'h20000
`define DRCTO_HOLD_C15 18'h28000
`define DRCTO_ATTACK_BASE 24'h800000
`define DRCTO_DECAY_BASE 24'h008000

`endif

// file: hw/drcto_timing_control.v
// Behaviour
// - hold code zero skips hold phase
// - hold field bits 6:3, 32 doubling up to code 12, 13 holds 98304
// - code 15 holds 163840, 14 holds 131072
// - attack field 7:4, 4 dB halving
// - slowest attack codes give tiny steps
// - decay is 0.015625 dB over 2^code
// - compressor runs only when enabled
// - threshold -3 to -24 dB, reset -12
`timescale 1ns/1ps
`default_nettype none
`include "drcto_consts.vh"

module drcto_timing_control (
  input wire i_sys_clk,
  input wire i_nrst,
  input wire [6:0] i_reg_addr,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_wdata,
  input wire i_word_tick,
  input wire i_over_threshold,
  input wire i_gain_restored,
  output reg [7:0] o_reg_rdata,
  output reg o_enable,
  output reg [2:0] o_threshold_code,
  output reg [1:0] o_hysteresis_code,
  output reg o_attack_active,
  output reg o_hold_active,
  output reg o_decay_active,
  output reg [23:0] o_attack_step,
  output reg [23:0] o_decay_step
);

  // ==========================================================
  // helpers
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ATTACK = 2'd1;
  localparam [1:0] ST_HOLD = 2'd2;
  localparam [1:0] ST_DECAY = 2'd3;

  // hold length in word clocks for a nonzero code
  function [17:0] drcto_hold_len;
    input [3:0] code;
    begin
      case (code)
        4'hd: drcto_hold_len = `DRCTO_HOLD_C13;
        4'he: drcto_hold_len = `DRCTO_HOLD_C14;
        4'hf: drcto_hold_len = `DRCTO_HOLD_C15;
        4'h0: drcto_hold_len = 18'h00000;
        default: drcto_hold_len = `DRCTO_HOLD_BASE << (code - 4'h1);
      endcase
    end
  endfunction

  // step size halves with each code
  function [23:0] drcto_rate;
    input [23:0] base;
    input [3:0] code;
    begin
      drcto_rate = base >> code;
    end
  endfunction

  // write strobe aimed at one register offset
  function drcto_hit;
    input strobe;
    input [6:0] addr;
    input [6:0] target;
    begin
      drcto_hit = strobe && (addr == target);
    end
  endfunction

  // ==========================================================
  // registers
  reg [7:0] ctrl;
  reg [3:0] hold_code;
  reg [3:0] attack_code;
  reg [3:0] decay_code;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [17:0] hold_cnt;
  reg [17:0] next_hold_cnt;

  // control register, stored whole
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= `DRCTO_RST_CTRL;
    end else if (drcto_hit(i_reg_wr, i_reg_addr, `DRCTO_ADDR_CTRL)) begin
      ctrl <= i_reg_wdata;
    end
  end

  // hold code; reserved bits of this register are not stored
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hold_code <= `DRCTO_RST_HOLD;
    end else if (drcto_hit(i_reg_wr, i_reg_addr, `DRCTO_ADDR_HOLD)) begin
      hold_code <= i_reg_wdata[`DRCTO_HOLD_HI:`DRCTO_HOLD_LO];
    end
  end

  // attack and decay codes share one register
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      attack_code <= `DRCTO_RST_ATTACK;
      decay_code <= `DRCTO_RST_DECAY;
    end else if (drcto_hit(i_reg_wr, i_reg_addr, `DRCTO_ADDR_RATE)) begin
      attack_code <= i_reg_wdata[`DRCTO_ATTACK_HI:`DRCTO_ATTACK_LO];
      decay_code <= i_reg_wdata[`DRCTO_DECAY_HI:`DRCTO_DECAY_LO];
    end
  end

  // registered read data, unmapped reads zero
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `DRCTO_ADDR_CTRL: o_reg_rdata <= ctrl;
        `DRCTO_ADDR_HOLD: o_reg_rdata <= {1'b0, hold_code, 3'b000};
        `DRCTO_ADDR_RATE: o_reg_rdata <= {attack_code, decay_code};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // attack / hold / decay sequencer
  always @* begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    if (!ctrl[`DRCTO_CTRL_EN_BIT]) begin
      next_state = ST_IDLE;
      next_hold_cnt = 18'h00000;
    end else if (i_word_tick) begin
      case (state)
        ST_IDLE: begin
          if (i_over_threshold) begin
            next_state = ST_ATTACK;
          end
        end
        ST_ATTACK: begin
          if (!i_over_threshold) begin
            if (hold_code == 4'h0) begin
              next_state = ST_DECAY;
            end else begin
              next_state = ST_HOLD;
              next_hold_cnt = drcto_hold_len(hold_code) - 18'h00001;
            end
          end
        end
        ST_HOLD: begin
          if (i_over_threshold) begin
            next_state = ST_ATTACK;
          end else if (hold_cnt == 18'h00000) begin
            next_state = ST_DECAY;
          end else begin
            next_hold_cnt = hold_cnt - 18'h00001;
          end
        end
        ST_DECAY: begin
          if (i_over_threshold) begin
            next_state = ST_ATTACK;
          end else if (i_gain_restored) begin
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // state and hold counter
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      hold_cnt <= 18'h00000;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
    end
  end

  // ==========================================================
  // outputs

  // control fields mirrored to the datapath
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_enable <= 1'h0;
      o_threshold_code <= `DRCTO_RST_THR;
      o_hysteresis_code <= `DRCTO_RST_HYS;
    end else begin
      o_enable <= ctrl[`DRCTO_CTRL_EN_BIT];
      o_threshold_code <= ctrl[`DRCTO_CTRL_THR_HI:`DRCTO_CTRL_THR_LO];
      o_hysteresis_code <= ctrl[`DRCTO_CTRL_HYS_HI:`DRCTO_CTRL_HYS_LO];
    end
  end

  // phase flags follow the next state, so they move on the tick edge
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_attack_active <= 1'h0;
      o_hold_active <= 1'h0;
      o_decay_active <= 1'h0;
    end else begin
      o_attack_active <= (next_state == ST_ATTACK);
      o_hold_active <= (next_state == ST_HOLD);
      o_decay_active <= (next_state == ST_DECAY);
    end
  end

  // step sizes per word clock, lsb is 2^-21 dB
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_attack_step <= `DRCTO_ATTACK_BASE;
      o_decay_step <= `DRCTO_DECAY_BASE;
    end else begin
      o_attack_step <= drcto_rate(`DRCTO_ATTACK_BASE, attack_code);
      o_decay_step <= drcto_rate(`DRCTO_DECAY_BASE, decay_code);
    end
  end

endmodule
`default_nettype wire

// file: tb/drcto_timing_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module drcto_timing_checker (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_word_tick,
  input wire logic i_over_threshold,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_enable,
  input wire logic o_attack_active,
  input wire logic o_hold_active,
  input wire logic o_decay_active,
  input wire logic [23:0] o_attack_step,
  input wire logic [23:0] o_decay_step
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // decoded accesses
  wire w44 = i_reg_wr && i_reg_addr == 7'h44;
  wire w46 = i_reg_wr && i_reg_addr == 7'h46;
  wire [2:0] ph = {o_attack_active, o_hold_active, o_decay_active};
  sequence s_restart;
    o_hold_active && i_word_tick && i_over_threshold && o_enable && !$past(w44);
  endsequence
  a_attack_step: assert property (w46 |-> ##2 o_attack_step ==
    24'h800000 >> $past(i_reg_wdata[7:4], 2)) else $error("attack step");
  a_decay_step: assert property (w46 |-> ##2 o_decay_step ==
    24'h008000 >> $past(i_reg_wdata[3:0], 2)) else $error("decay step");
  a_hold_read: assert property (i_reg_rd && i_reg_addr == 7'h45 |=>
    o_reg_rdata[7] == 0 && o_reg_rdata[2:0] == 0) else $error("reserved bits");
  a_unmapped_read: assert property (i_reg_rd && i_reg_addr > 7'h46 |=>
    o_reg_rdata == 0) else $error("unmapped read");
  a_phase_onehot: assert property ($onehot0(ph)) else $error("phases");
  a_enable_off: assert property (w44 && !i_reg_wdata[6] |-> ##3 ph == 0)
    else $error("disabled active");
  a_attack_entry: assert property ($rose(o_attack_active) |->
    $past(i_word_tick && i_over_threshold)) else $error("attack entry");
  a_hold_restart: assert property (s_restart |=> o_attack_active)
    else $error("hold restart");
endmodule
bind drcto_timing_control drcto_timing_checker i_chk (
  .i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata),
  .i_word_tick(i_word_tick),
  .i_over_threshold(i_over_threshold),
  .o_reg_rdata(o_reg_rdata),
  .o_enable(o_enable),
  .o_attack_active(o_attack_active),
  .o_hold_active(o_hold_active),
  .o_decay_active(o_decay_active),
  .o_attack_step(o_attack_step),
  .o_decay_step(o_decay_step)
);
`default_nettype wire

// file: tb/drcto_timing_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// testbench
module drcto_timing_control_test;
  logic i_sys_clk = 0, i_nrst = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic i_word_tick = 0, i_over_threshold = 0, i_gain_restored = 0;
  logic [6:0] i_reg_addr = 0;
  logic [7:0] i_reg_wdata = 0, seed = 8'h5f, d;
  wire [7:0] o_reg_rdata;
  wire [2:0] o_threshold_code;
  wire [1:0] o_hysteresis_code;
  wire o_enable, o_attack_active, o_hold_active, o_decay_active;
  wire [23:0] o_attack_step, o_decay_step;
  int n_mismatch = 0, check_count = 0;
  drcto_timing_control i_dut (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .i_word_tick(i_word_tick),
    .i_over_threshold(i_over_threshold),
    .i_gain_restored(i_gain_restored),
    .o_reg_rdata(o_reg_rdata),
    .o_enable(o_enable),
    .o_threshold_code(o_threshold_code),
    .o_hysteresis_code(o_hysteresis_code),
    .o_attack_active(o_attack_active),
    .o_hold_active(o_hold_active),
    .o_decay_active(o_decay_active),
    .o_attack_step(o_attack_step),
    .o_decay_step(o_decay_step)
  );
  // clock
  initial begin
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  function automatic [7:0] lfsr(input [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic [23:0] step(input [23:0] b, input [3:0] c);
    return b >> c;
  endfunction
  task automatic check(input [23:0] got, input [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input [6:0] a, input [7:0] v);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_wr <= 1;
    @(posedge i_sys_clk);
    i_reg_wr <= 0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic rd(input [6:0] a, input [7:0] e);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1;
    @(posedge i_sys_clk);
    i_reg_rd <= 0;
    #1 check(o_reg_rdata, e);
  endtask
  task automatic tick(input o, input g, input [2:0] p);
    @(posedge i_sys_clk);
    i_word_tick <= 1;
    i_over_threshold <= o;
    i_gain_restored <= g;
    @(posedge i_sys_clk);
    i_word_tick <= 0;
    #1 check({o_attack_active, o_hold_active, o_decay_active}, p);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #1000000 n_mismatch++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_nrst <= 1;
    rd(7'h44, 8'h0f);
    rd(7'h45, 8'h38);
    rd(7'h46, 8'h00);
    rd(7'h47, 8'h00);
    check(o_threshold_code, 3);
    check(o_hysteresis_code, 3);
    wr(7'h45, 8'h78);
    rd(7'h45, 8'h78);
    for (int i = 0; i < 18; i++) begin
      d = i < 2 ? {8{i[0]}} : seed;
      seed = lfsr(seed);
      wr(7'h46, d);
      check(o_attack_step, step(24'h800000, d[7:4]));
      check(o_decay_step, step(24'h008000, d[3:0]));
    end
    wr(7'h44, 8'h46);
    rd(7'h44, 8'h46);
    check(o_enable, 1);
    check(o_threshold_code, 1);
    check(o_hysteresis_code, 2);
    wr(7'h45, 8'h08);
    tick(1, 0, 3'b100);
    tick(0, 0, 3'b010);
    tick(1, 0, 3'b100);
    tick(0, 0, 3'b010);
    repeat (31) tick(0, 0, 3'b010);
    tick(0, 0, 3'b001);
    tick(0, 1, 3'b000);
    // longest hold code must outlast the code 12 interval of 65536 word clocks
    wr(7'h45, 8'h78);
    tick(1, 0, 3'b100);
    tick(0, 0, 3'b010);
    @(posedge i_sys_clk);
    i_word_tick <= 1;
    repeat (65600) @(posedge i_sys_clk);
    i_word_tick <= 0;
    #1 check({o_attack_active, o_hold_active, o_decay_active}, 3'b010);
    tick(1, 0, 3'b100);
    wr(7'h45, 8'h00);
    tick(1, 0, 3'b100);
    tick(0, 0, 3'b001);
    wr(7'h44, 8'h0f);
    check(o_enable, 0);
    check(o_threshold_code, 3);
    tick(1, 0, 3'b000);
    // reset again in mid-run, the defaults must come back
    @(posedge i_sys_clk);
    i_nrst <= 0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1;
    rd(7'h45, 8'h38);
    rd(7'h46, 8'h00);
    check(o_attack_step, 24'h800000);
    check(o_decay_step, 24'h008000);
    end_of_test;
  end
endmodule
`default_nettype wire
